// ---- include/mtb_pkg.sv ----
/*
 * mtb_pkg: register map, field layout, reset values and state types
 * for the motor pwm time base.
 * assumes pclk is the instruction clock (oscillator divided by four).
 */
package mtb_pkg;
   // byte addresses of the apb registers
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_COUNTER = 8'h04;
   localparam logic [7:0] ADDR_PERIOD = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_ACTIVE = 8'h10;
   // timebase_control fields, counter direction bit and status flag bit
   localparam int CTL_RUN_BIT = 15;
   localparam int CTL_POST_LSB = 4;
   localparam int CTL_PRE_LSB = 2;
   localparam int CTL_MODE_LSB = 0;
   localparam int CNT_DIR_BIT = 15;
   localparam int STS_FLAG_BIT = 0;
   // reset values and count steps
   localparam logic [14:0] CNT_RESET = 15'h0000;
   localparam logic [14:0] PER_RESET = 15'h0000;
   localparam logic [14:0] CNT_ONE = 15'h0001;
   localparam logic [3:0] POST_ONE = 4'h1;
   localparam logic [5:0] PRE_ONE = 6'h01;
   // prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
   localparam logic [5:0] PRE_LIM_1 = 6'h00;
   localparam logic [5:0] PRE_LIM_4 = 6'h03;
   localparam logic [5:0] PRE_LIM_16 = 6'h0F;
   localparam logic [5:0] PRE_LIM_64 = 6'h3F;

   typedef enum logic [1:0] {
      MTB_FREE = 2'h0,
      MTB_SINGLE = 2'h1,
      MTB_UPDOWN = 2'h2,
      MTB_DOUBLE = 2'h3
   } mtb_mode_t;

   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
   } mtb_pairs_t;

   typedef struct packed {
      logic run;
      mtb_mode_t mode;
      logic [1:0] pre_sel;
      logic [3:0] post_sel;
      logic [14:0] cnt;
      logic dir;
      logic [14:0] per_buf;
      logic [14:0] per_act;
      logic [5:0] pre_cnt;
      logic [3:0] post_cnt;
      logic evt;
      logic flag;
      logic ready;
      logic slverr;
      logic [31:0] rdata;
      mtb_pairs_t pairs;
   } mtb_state_t;
endpackage : mtb_pkg

// ---- hw/mtb_time_base.sv ----
/*
 * mtb_time_base: 15-bit pwm time base with prescaler, postscaler,
 * double-buffered period, four counting modes and an apb slave.
 * assumes pclk is the instruction clock; duty comparators outside
 * drive duty_high_in; an interrupt controller takes event_pulse.
 */
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module mtb_time_base (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] duty_high_in,
   output logic pair1_high_out,
   output logic pair1_low_out,
   output logic pair2_high_out,
   output logic pair2_low_out,
   output logic pair3_high_out,
   output logic pair3_low_out,
   output logic [14:0] timebase_counter,
   output logic count_down_flag,
   output logic event_pulse,
   output logic event_flag
);
   mtb_pkg::mtb_state_t st_reg;
   mtb_pkg::mtb_state_t st_next;
   logic acc;
   logic wr;
   logic mapped;
   logic wr_ctl;
   logic wr_cnt;
   logic tick;
   logic match;
   logic live;
   logic raw_evt;
   logic scaled;
   logic reload;

   function automatic logic [5:0] pre_limit(input logic [1:0] sel);
      logic [5:0] lim;
      unique case (sel)
         2'h0: lim = mtb_pkg::PRE_LIM_1;
         2'h1: lim = mtb_pkg::PRE_LIM_4;
         2'h2: lim = mtb_pkg::PRE_LIM_16;
         default: lim = mtb_pkg::PRE_LIM_64;
      endcase
      return lim;
   endfunction : pre_limit

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction : is_addr

   // access phase completes on the second cycle: one wait state
   assign acc = psel && penable && st_reg.ready;
   assign wr = acc && pwrite;
   assign mapped = is_addr(paddr, mtb_pkg::ADDR_CONTROL)
      || is_addr(paddr, mtb_pkg::ADDR_COUNTER)
      || is_addr(paddr, mtb_pkg::ADDR_PERIOD)
      || is_addr(paddr, mtb_pkg::ADDR_STATUS)
      || is_addr(paddr, mtb_pkg::ADDR_ACTIVE);
   assign wr_ctl = wr && is_addr(paddr, mtb_pkg::ADDR_CONTROL);
   assign wr_cnt = wr && is_addr(paddr, mtb_pkg::ADDR_COUNTER);
   assign tick = st_reg.pre_cnt == pre_limit(st_reg.pre_sel);
   // match compares the low 15 bits only
   assign match = st_reg.cnt == st_reg.per_act;
   // a zero period freezes the counter
   assign live = st_reg.run && tick && (st_reg.per_act != mtb_pkg::PER_RESET);

   always_comb begin
      st_next = st_reg;
      raw_evt = 1'b0;
      scaled = 1'b0;
      reload = 1'b0;
      st_next.evt = 1'b0;

      if (tick) begin
         st_next.pre_cnt = '0;
      end else begin
         st_next.pre_cnt = st_reg.pre_cnt + mtb_pkg::PRE_ONE;
      end

      // edge modes always count up, so a stale down flag is dropped
      if (st_reg.mode == mtb_pkg::MTB_FREE
            || st_reg.mode == mtb_pkg::MTB_SINGLE) begin
         st_next.dir = 1'b0;
      end

      // only a live tick moves the counter
      if (live) begin
         // mode field picks the counting scheme
         unique case (st_reg.mode)
            mtb_pkg::MTB_FREE, mtb_pkg::MTB_SINGLE: begin
               if (match) begin
                  // wrap to zero with one event
                  st_next.cnt = mtb_pkg::CNT_RESET;
                  raw_evt = 1'b1;
                  scaled = st_reg.mode == mtb_pkg::MTB_FREE;
                  reload = 1'b1;
                  if (st_reg.mode == mtb_pkg::MTB_SINGLE) begin
                     st_next.run = 1'b0;
                  end
               end else begin
                  st_next.cnt = st_reg.cnt + mtb_pkg::CNT_ONE;
               end
            end
            mtb_pkg::MTB_UPDOWN, mtb_pkg::MTB_DOUBLE: begin
               // turning ticks hold the count, giving 2*(P+1)
               if (!st_reg.dir && match) begin
                  st_next.dir = 1'b1;
                  // event at period match in double update
                  raw_evt = st_reg.mode == mtb_pkg::MTB_DOUBLE;
               end else if (st_reg.dir && st_reg.cnt == mtb_pkg::CNT_RESET) begin
                  st_next.dir = 1'b0;
                  raw_evt = 1'b1;
                  scaled = st_reg.mode == mtb_pkg::MTB_UPDOWN;
                  reload = 1'b1;
               end else if (st_reg.dir) begin
                  st_next.cnt = st_reg.cnt - mtb_pkg::CNT_ONE;
               end else begin
                  st_next.cnt = st_reg.cnt + mtb_pkg::CNT_ONE;
               end
            end
         endcase
      end

      // postscaler divides by post_sel+1 in free and up/down modes
      if (raw_evt && scaled) begin
         if (st_reg.post_cnt == st_reg.post_sel) begin
            st_next.post_cnt = '0;
            st_next.evt = 1'b1;
         end else begin
            st_next.post_cnt = st_reg.post_cnt + mtb_pkg::POST_ONE;
         end
      end else if (raw_evt) begin
         st_next.evt = 1'b1;
      end

      // active period takes the buffer at its update point
      if (reload) begin
         st_next.per_act = st_reg.per_buf;
      end
      // idle time base tracks the buffer
      if (!st_reg.run) begin
         st_next.per_act = st_reg.per_buf;
      end

      // register writes; a write overrides the counting above
      if (wr_ctl) begin
         st_next.run = pwdata[mtb_pkg::CTL_RUN_BIT];
         st_next.mode = mtb_pkg::mtb_mode_t'(pwdata[mtb_pkg::CTL_MODE_LSB +: 2]);
         st_next.pre_sel = pwdata[mtb_pkg::CTL_PRE_LSB +: 2];
         st_next.post_sel = pwdata[mtb_pkg::CTL_POST_LSB +: 4];
      end
      if (wr_cnt) begin
         st_next.cnt = pwdata[14:0];
      end
      // any counter or control write clears both scalers
      if (wr_ctl || wr_cnt) begin
         st_next.pre_cnt = '0;
         st_next.post_cnt = '0;
      end
      if (wr && is_addr(paddr, mtb_pkg::ADDR_PERIOD)) begin
         st_next.per_buf = pwdata[14:0];
      end

      // sticky flag: a new event wins over the clearing write
      if (wr && is_addr(paddr, mtb_pkg::ADDR_STATUS)
            && pwdata[mtb_pkg::STS_FLAG_BIT]) begin
         st_next.flag = 1'b0;
      end
      if (st_next.evt) begin
         st_next.flag = 1'b1;
      end

      // high outputs only while running; low is the inverse
      st_next.pairs.high = duty_high_in & {3{st_next.run}};
      st_next.pairs.low = ~st_next.pairs.high;

      // apb: first access cycle latches the answer, second completes
      st_next.ready = psel && penable && !st_reg.ready;
      st_next.slverr = st_next.ready && !mapped;
      st_next.rdata = '0;
      if (st_next.ready && !pwrite) begin
         if (is_addr(paddr, mtb_pkg::ADDR_CONTROL)) begin
            st_next.rdata[mtb_pkg::CTL_RUN_BIT] = st_reg.run;
            st_next.rdata[mtb_pkg::CTL_MODE_LSB +: 2] = st_reg.mode;
            st_next.rdata[mtb_pkg::CTL_PRE_LSB +: 2] = st_reg.pre_sel;
            st_next.rdata[mtb_pkg::CTL_POST_LSB +: 4] = st_reg.post_sel;
         end else if (is_addr(paddr, mtb_pkg::ADDR_COUNTER)) begin
            // top bit shows the count direction
            st_next.rdata[14:0] = st_reg.cnt;
            st_next.rdata[mtb_pkg::CNT_DIR_BIT] = st_reg.dir;
         end else if (is_addr(paddr, mtb_pkg::ADDR_PERIOD)) begin
            st_next.rdata[14:0] = st_reg.per_buf;
         end else if (is_addr(paddr, mtb_pkg::ADDR_STATUS)) begin
            st_next.rdata[mtb_pkg::STS_FLAG_BIT] = st_reg.flag;
         end else if (is_addr(paddr, mtb_pkg::ADDR_ACTIVE)) begin
            st_next.rdata[14:0] = st_reg.per_act;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.pairs.low <= 3'h7;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.rdata;
   assign pready = st_reg.ready;
   assign pslverr = st_reg.slverr;
   assign pair1_high_out = st_reg.pairs.high[0];
   assign pair1_low_out = st_reg.pairs.low[0];
   assign pair2_high_out = st_reg.pairs.high[1];
   assign pair2_low_out = st_reg.pairs.low[1];
   assign pair3_high_out = st_reg.pairs.high[2];
   assign pair3_low_out = st_reg.pairs.low[2];
   assign timebase_counter = st_reg.cnt;
   assign count_down_flag = st_reg.dir;
   assign event_pulse = st_reg.evt;
   assign event_flag = st_reg.flag;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_halt_holds: assert property (
      !st_reg.run && !wr_cnt |=> $stable(st_reg.cnt))
      else $error("counter moved while halted");
   chk_free_wrap: assert property (
      live && match && st_reg.mode == mtb_pkg::MTB_FREE && !wr_cnt
      |=> st_reg.cnt == mtb_pkg::CNT_RESET)
      else $error("free running counter did not wrap");
   chk_zero_period: assert property (
      st_reg.run && st_reg.per_act == mtb_pkg::PER_RESET && !wr_cnt
      |=> $stable(st_reg.cnt) && !st_reg.evt)
      else $error("zero period did not stop the counter");
   chk_single_stop: assert property (
      live && match && st_reg.mode == mtb_pkg::MTB_SINGLE && !wr_ctl
      |=> !st_reg.run && st_reg.evt && st_reg.pairs.high == 3'h0)
      else $error("single shot did not halt with one event");
   chk_updown_turn: assert property (
      live && match && !st_reg.dir && st_reg.mode[1] && !wr_cnt
      |=> st_reg.dir)
      else $error("up/down counter did not turn down");
   chk_presc_clear: assert property (
      wr_ctl || wr_cnt |=> st_reg.pre_cnt == 6'h00)
      else $error("prescaler not cleared by write");
   chk_post_clear: assert property (
      wr_ctl || wr_cnt |=> st_reg.post_cnt == 4'h0)
      else $error("postscaler not cleared by write");
   chk_idle_reload: assert property (
      !st_reg.run |=> st_reg.per_act == $past(st_reg.per_buf))
      else $error("idle period not copied from buffer");
   chk_pair_compl: assert property (
      st_reg.pairs.low == ~st_reg.pairs.high)
      else $error("low output not inverse of high");
   chk_flag_sticky: assert property (
      st_reg.evt |-> st_reg.flag ##1 !st_reg.evt [*1])
      else $error("event pulse not one clock or flag not set");
   chk_edge_upcount: assert property (
      st_reg.mode == mtb_pkg::MTB_FREE || st_reg.mode == mtb_pkg::MTB_SINGLE
      |=> !st_reg.dir)
      else $error("down flag set in an edge mode");
   chk_tick_only: assert property (
      !live && !wr_cnt
      |=> $stable(st_reg.cnt))
      else $error("counter moved without a live tick");
   chk_up_step: assert property (
      live && !match && !st_reg.dir && !wr_cnt
      |=> st_reg.cnt == $past(st_reg.cnt) + mtb_pkg::CNT_ONE)
      else $error("counter did not step up by one");
   chk_down_step: assert property (
      live && st_reg.dir && st_reg.cnt != mtb_pkg::CNT_RESET
      && st_reg.mode[1] && !wr_cnt
      |=> st_reg.cnt == $past(st_reg.cnt) - mtb_pkg::CNT_ONE)
      else $error("counter did not step down by one");
   chk_zero_event: assert property (
      live && st_reg.dir && st_reg.cnt == mtb_pkg::CNT_RESET
      && st_reg.mode == mtb_pkg::MTB_UPDOWN
      && st_reg.post_cnt == st_reg.post_sel
      |=> st_reg.evt && !st_reg.dir)
      else $error("no event where zero turns upward");
   chk_post_hold: assert property (
      raw_evt && scaled && st_reg.post_cnt != st_reg.post_sel
      |=> !st_reg.evt)
      else $error("postscaler passed an event too early");
   chk_double_event: assert property (
      live && st_reg.mode == mtb_pkg::MTB_DOUBLE
      && (st_reg.dir ? st_reg.cnt == mtb_pkg::CNT_RESET : match)
      |=> st_reg.evt)
      else $error("double update event missing");
   chk_wrap_reload: assert property (
      live && match && !st_reg.mode[1]
      |=> st_reg.per_act == $past(st_reg.per_buf))
      else $error("period not reloaded at wrap");
   chk_zero_reload: assert property (
      live && st_reg.dir && st_reg.cnt == mtb_pkg::CNT_RESET
      && st_reg.mode[1]
      |=> st_reg.per_act == $past(st_reg.per_buf))
      else $error("period not reloaded at zero");
   chk_zero_no_reload: assert property (
      st_reg.run && st_reg.per_act == mtb_pkg::PER_RESET
      |=> st_reg.per_act == mtb_pkg::PER_RESET)
      else $error("zero period reloaded while running");
   chk_pair_follow: assert property (
      st_reg.pairs.high == ($past(duty_high_in) & {3{st_reg.run}}))
      else $error("high outputs do not follow duty while running");
   chk_flag_clear: assert property (
      wr && is_addr(paddr, mtb_pkg::ADDR_STATUS)
      && pwdata[mtb_pkg::STS_FLAG_BIT] && !st_next.evt
      |=> !st_reg.flag)
      else $error("event flag not cleared by write");
endmodule : mtb_time_base

// ---- verification/mtb_power_stage.sv ----
/*
 * mtb_power_stage: stand-in for the switching stage on the pwm pairs;
 * it also plays the duty comparators feeding duty_high_in.
 * assumes pclk is the time base clock and presetn its reset.
 */
`timescale 1ns/1ps
module mtb_power_stage (
   input wire logic pclk,
   input wire logic presetn,
   input wire mtb_pkg::mtb_pairs_t pairs,
   output logic [2:0] duty,
   output int bad
);
   // duty pattern changes every cycle so both levels reach each pair
   always @(posedge pclk) begin
      if (!presetn) begin
         duty <= 3'h5;
         bad <= 0;
      end else begin
         duty <= duty + 3'h3;
         if (pairs.low !== ~pairs.high) begin
            bad <= bad + 1;
         end
      end
   end
endmodule : mtb_power_stage

// ---- verification/test_motor_pwm_time_base.sv ----
/*
 * test_motor_pwm_time_base: directed scenarios for the time base.
 * assumes the apb slave answers with pready and a period of three.
 */
`timescale 1ns/1ps
module test_motor_pwm_time_base;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, serr, event_pulse, event_flag, saw_down;
   logic p1h, p1l, p2h, p2l, p3h, p3l, count_down_flag;
   logic [2:0] duty;
   logic [14:0] timebase_counter;
   mtb_pkg::mtb_pairs_t pairs;
   int err_count = 0, n_checks = 0, ps_bad, n, m;
   assign pairs.high = {p3h, p2h, p1h};
   assign pairs.low = {p3l, p2l, p1l};
   always #20 pclk = ~pclk;
   mtb_time_base uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .duty_high_in(duty), .pair1_high_out(p1h),
      .pair1_low_out(p1l), .pair2_high_out(p2h), .pair2_low_out(p2l),
      .pair3_high_out(p3h), .pair3_low_out(p3l),
      .timebase_counter(timebase_counter),
      .count_down_flag(count_down_flag), .event_pulse(event_pulse),
      .event_flag(event_flag));
   mtb_power_stage ps (.pclk(pclk), .presetn(presetn), .pairs(pairs),
      .duty(duty), .bad(ps_bad));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         err_count++;
         wrap_up();
      end
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   function automatic logic [31:0] ctl(logic r, logic [3:0] po,
         logic [1:0] pr, logic [1:0] md);
      return {16'h0, r, 7'h00, po, pr, md};
   endfunction : ctl
   task automatic wait_evt(output int i);
      for (i = 0; i < 3000 && event_pulse !== 1'b1; i++) @(posedge pclk);
      if (i >= 3000) begin
         err_count++;
         wrap_up();
      end
   endtask : wait_evt
   // cycles between two event pulses, noting any down count meanwhile
   task automatic gap(output int g);
      int i;
      wait_evt(i);
      g = 0;
      do begin
         @(posedge pclk);
         g++;
         if (count_down_flag === 1'b1) saw_down = 1'b1;
      end while (event_pulse !== 1'b1 && g < 3000);
      if (g >= 3000) begin
         err_count++;
         wrap_up();
      end
   endtask : gap
   task automatic s_regs;
      chk(timebase_counter, 15'h0000);
      chk(p1l, 1'b1);
      apb(1'b1, mtb_pkg::ADDR_PERIOD, 32'h3);
      apb(1'b0, mtb_pkg::ADDR_ACTIVE, 32'h0);
      chk(rdat, 32'h3);
      apb(1'b1, mtb_pkg::ADDR_COUNTER, 32'h5);
      apb(1'b0, mtb_pkg::ADDR_COUNTER, 32'h0);
      chk(rdat, 32'h5);
      chk({31'h0, serr}, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk(rdat, 32'h0);
      chk({31'h0, serr}, 32'h1);
      apb(1'b1, mtb_pkg::ADDR_COUNTER, 32'h0);
   endtask : s_regs
   task automatic s_free;
      apb(1'b1, mtb_pkg::ADDR_CONTROL, ctl(1'b1, 4'h0, 2'h1, 2'h0));
      gap(n);
      gap(n);
      chk(n, 16);
      @(posedge pclk);
      m = duty;
      @(posedge pclk);
      chk(pairs.high, m);
      apb(1'b1, mtb_pkg::ADDR_CONTROL, ctl(1'b1, 4'h1, 2'h0, 2'h0));
      gap(n);
      gap(n);
      chk(n, 8);
      apb(1'b1, mtb_pkg::ADDR_CONTROL, ctl(1'b0, 4'h0, 2'h0, 2'h0));
      apb(1'b0, mtb_pkg::ADDR_COUNTER, 32'h0);
      m = rdat;
      repeat (10) @(posedge pclk);
      apb(1'b0, mtb_pkg::ADDR_COUNTER, 32'h0);
      chk(rdat, m);
   endtask : s_free
   task automatic s_updown;
      saw_down = 1'b0;
      apb(1'b1, mtb_pkg::ADDR_CONTROL, ctl(1'b1, 4'h0, 2'h0, 2'h2));
      gap(n);
      gap(n);
      chk(n, 8);
      chk(saw_down, 1'b1);
      apb(1'b1, mtb_pkg::ADDR_CONTROL, ctl(1'b1, 4'h2, 2'h0, 2'h2));
      gap(n);
      gap(n);
      chk(n, 24);
      apb(1'b1, mtb_pkg::ADDR_CONTROL, ctl(1'b1, 4'h3, 2'h0, 2'h3));
      gap(n);
      gap(n);
      gap(m);
      chk(n + m, 8);
   endtask : s_updown
   task automatic s_single;
      apb(1'b1, mtb_pkg::ADDR_CONTROL, ctl(1'b0, 4'h3, 2'h0, 2'h1));
      apb(1'b1, mtb_pkg::ADDR_COUNTER, 32'h0);
      apb(1'b1, mtb_pkg::ADDR_STATUS, 32'h1);
      apb(1'b0, mtb_pkg::ADDR_STATUS, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b1, mtb_pkg::ADDR_CONTROL, ctl(1'b1, 4'h3, 2'h0, 2'h1));
      wait_evt(n);
      chk(n < 8, 1'b1);
      repeat (2) @(posedge pclk);
      chk({p3h, p2h, p1h, timebase_counter}, 18'h0);
      apb(1'b0, mtb_pkg::ADDR_CONTROL, 32'h0);
      chk(rdat[15], 1'b0);
      apb(1'b0, mtb_pkg::ADDR_STATUS, 32'h0);
      chk(rdat, 32'h1);
   endtask : s_single
   task automatic s_zero;
      apb(1'b1, mtb_pkg::ADDR_PERIOD, 32'h0);
      apb(1'b1, mtb_pkg::ADDR_STATUS, 32'h1);
      apb(1'b1, mtb_pkg::ADDR_CONTROL, ctl(1'b1, 4'h0, 2'h0, 2'h0));
      repeat (40) @(posedge pclk);
      chk({event_flag, timebase_counter}, 16'h0);
      apb(1'b1, mtb_pkg::ADDR_PERIOD, 32'h3);
      apb(1'b0, mtb_pkg::ADDR_ACTIVE, 32'h0);
      chk(rdat, 32'h0);
      chk(ps_bad, 0);
   endtask : s_zero
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_regs();
      s_free();
      s_updown();
      s_single();
      s_zero();
      wrap_up();
   end
endmodule : test_motor_pwm_time_base
